// ===== rtl/lps_pkg.sv
package lps_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] LPS_ADDR_STATUS_MAIN = 8'h00;
  localparam logic [7:0] LPS_ADDR_STATUS_SPARE = 8'h01;
  localparam logic [7:0] LPS_ADDR_POLICY = 8'h05;
  localparam logic [7:0] LPS_STATUS_RESET = 8'h00;
  localparam logic [7:0] LPS_POLICY_RESET = 8'h00;
  localparam logic [7:0] LPS_POLICY_WMASK = 8'h5f;
  localparam logic [3:0] LPS_LEVEL_RESET = 4'h0;
  localparam logic [7:0] LPS_RDATA_RESET = 8'h00;
  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int LPS_BIT_OVERLOAD_A = 0;
  localparam int LPS_BIT_OVERLOAD_B = 1;
  localparam int LPS_BIT_OVERTEMP = 6;
  localparam int LPS_BIT_LOW_SUPPLY = 7;
  localparam int LPS_BIT_THERMAL_POLICY = 6;
  localparam int LPS_BIT_OVERLOAD_POLICY = 3;
  // ---------------------------------------------------------------------------
  // Output gate states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    LPS_OUT_ON = 2'b00,
    LPS_OUT_HELD = 2'b01,
    LPS_OUT_LATCHED = 2'b11
  } lps_out_type;
endpackage

// ===== rtl/lps_sync_if.sv
`timescale 1ns/1ps
interface lps_sync_if;
  logic raw;
  logic synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface

// ===== rtl/lps_sync.sv
`timescale 1ns/1ps
module lps_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level in and out
  lps_sync_if.dst port
);
  logic meta_q, meta_d, sync_q, sync_d;

  always_comb begin
    meta_d = port.raw;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign port.synced = sync_q;
endmodule // lps_sync

// ===== rtl/lps_protection_status_regs.sv
`timescale 1ns/1ps
// Functional notes
// - Policy 1 and overtemperature clear all four level bits, disable output.
// - Policy 1: output stays off after flag clears until master rewrites level.
// - Policy 0: output off during overtemperature, returns with stored level.
// - Status registers read-only; writes to them ignored.
// - Status bit 0 shows section A overload.
// - Status bit 1 shows section B overload.
// - Status bit 6 shows overtemperature; hysteresis comes from comparator.
// - Status bit 7 shows input supply below low-power threshold.
// - Main status at address 0x0; bits 2 to 5 reserved.
// - Spare status at address 0x1; all bits reserved.
// - Both status registers clear to zero at power-on.
// - Overload restart policy 0 re-enables output once overload clears.
module lps_protection_status_regs
  import lps_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register access from the bus slave
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // Level select write strobes from the level register
  input wire logic levelWriteA,
  input wire logic levelWriteB,
  input wire logic [3:0] levelWdataA,
  input wire logic [3:0] levelWdataB,
  // Protection comparators
  input wire logic overloadRawA,
  input wire logic overloadRawB,
  input wire logic overtempRaw,
  input wire logic lowSupplyRaw,
  // Outputs to the power stages
  output logic outputEnableA,
  output logic outputEnableB,
  output logic [3:0] outputLevelSelectA,
  output logic [3:0] outputLevelSelectB,
  output logic [7:0] policyReg
);
  import lps_pkg::*;

  // ---------------------------------------------------------------------------
  // Comparator synchronisers
  // ---------------------------------------------------------------------------
  logic [3:0] rawVec;
  logic [3:0] syncVec;
  assign rawVec = {lowSupplyRaw, overtempRaw, overloadRawB, overloadRawA};

  for (genvar i = 0; i < 4; i++) begin : gSync
    lps_sync_if sif ();
    assign sif.raw = rawVec[i];
    assign syncVec[i] = sif.synced;
    lps_sync uSync (
      .clk(clk),
      .rst(rst),
      .port(sif)
    );
  end

  logic overloadFlagSecA, overloadFlagSecB, overtempFlag, lowSupplyFlag;
  assign overloadFlagSecA = syncVec[0];
  assign overloadFlagSecB = syncVec[1];
  assign overtempFlag = syncVec[2];
  assign lowSupplyFlag = syncVec[3];

  // ---------------------------------------------------------------------------
  // Status and policy registers
  // ---------------------------------------------------------------------------
  logic [7:0] statusMain_q, statusMain_d;
  logic [7:0] statusSpare_q, statusSpare_d;
  logic [7:0] policy_q, policy_d;
  logic [7:0] rdata_q, rdata_d;

  // Status flags, one cycle behind the synchronisers
  always_comb begin
    statusMain_d = LPS_STATUS_RESET;
    statusMain_d[LPS_BIT_OVERLOAD_A] = overloadFlagSecA;
    statusMain_d[LPS_BIT_OVERLOAD_B] = overloadFlagSecB;
    statusMain_d[LPS_BIT_OVERTEMP] = overtempFlag;
    statusMain_d[LPS_BIT_LOW_SUPPLY] = lowSupplyFlag;
    statusSpare_d = LPS_STATUS_RESET;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      statusMain_q <= LPS_STATUS_RESET;
      statusSpare_q <= LPS_STATUS_RESET;
    end else begin
      statusMain_q <= statusMain_d;
      statusSpare_q <= statusSpare_d;
    end
  end

  // Policy register
  always_comb begin
    policy_d = policy_q;
    // Reserved bits are masked, so a stray one from the master has no effect
    if (regWrite && regAddr == LPS_ADDR_POLICY) begin
      policy_d = regWdata & LPS_POLICY_WMASK;
    end
    // Status addresses fall through: writes there change nothing
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      policy_q <= LPS_POLICY_RESET;
    end else begin
      policy_q <= policy_d;
    end
  end

  // Read data holds until the next read
  always_comb begin
    rdata_d = rdata_q;
    if (regRead) begin
      unique case (regAddr)
        LPS_ADDR_STATUS_MAIN: rdata_d = statusMain_q;
        LPS_ADDR_STATUS_SPARE: rdata_d = statusSpare_q;
        LPS_ADDR_POLICY: rdata_d = policy_q;
        default: rdata_d = LPS_RDATA_RESET;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= LPS_RDATA_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Output gating per section
  // ---------------------------------------------------------------------------
  logic thermalRestartPolicy, overloadRestartPolicy;
  assign thermalRestartPolicy = policy_q[LPS_BIT_THERMAL_POLICY];
  assign overloadRestartPolicy = policy_q[LPS_BIT_OVERLOAD_POLICY];

  lps_out_type stateA_q, stateA_d, stateB_q, stateB_d;
  logic [3:0] levelA_q, levelA_d, levelB_q, levelB_d;
  logic enA_q, enA_d, enB_q, enB_d;

  function automatic lps_out_type nextState(
    input lps_out_type cur, input logic fault, input logic overload, input logic wr
  );
    lps_out_type n;
    n = cur;
    unique case (cur)
      LPS_OUT_ON: begin
        if (fault && thermalRestartPolicy) n = LPS_OUT_LATCHED;
        else if (fault || overload) n = LPS_OUT_HELD;
      end
      LPS_OUT_HELD: begin
        if (fault && thermalRestartPolicy) n = LPS_OUT_LATCHED;
        else if (!fault && !overload) n = LPS_OUT_ON;
      end
      LPS_OUT_LATCHED: begin
        // Only a fresh level write restarts; the master owns the recovery
        if (!fault && wr) n = LPS_OUT_ON;
      end
      default: n = LPS_OUT_LATCHED;
    endcase
    return n;
  endfunction

  // Section A
  always_comb begin
    // Overload with restart policy 1 is masked here and never closes the gate
    stateA_d = nextState(stateA_q, overtempFlag,
                         overloadFlagSecA && !overloadRestartPolicy, levelWriteA);
    levelA_d = levelWriteA ? levelWdataA : levelA_q;
    if (overtempFlag && thermalRestartPolicy) begin
      levelA_d = LPS_LEVEL_RESET;
    end
    // Level zero is standby, so the stage stays off without a level
    enA_d = (stateA_d == LPS_OUT_ON) && (levelA_d != LPS_LEVEL_RESET);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stateA_q <= LPS_OUT_ON;
      levelA_q <= LPS_LEVEL_RESET;
      enA_q <= 1'b0;
    end else begin
      stateA_q <= stateA_d;
      levelA_q <= levelA_d;
      enA_q <= enA_d;
    end
  end

  // Section B
  always_comb begin
    stateB_d = nextState(stateB_q, overtempFlag,
                         overloadFlagSecB && !overloadRestartPolicy, levelWriteB);
    levelB_d = levelWriteB ? levelWdataB : levelB_q;
    if (overtempFlag && thermalRestartPolicy) begin
      levelB_d = LPS_LEVEL_RESET;
    end
    enB_d = (stateB_d == LPS_OUT_ON) && (levelB_d != LPS_LEVEL_RESET);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stateB_q <= LPS_OUT_ON;
      levelB_q <= LPS_LEVEL_RESET;
      enB_q <= 1'b0;
    end else begin
      stateB_q <= stateB_d;
      levelB_q <= levelB_d;
      enB_q <= enB_d;
    end
  end

  assign regRdata = rdata_q;
  assign outputEnableA = enA_q;
  assign outputEnableB = enB_q;
  assign outputLevelSelectA = levelA_q;
  assign outputLevelSelectB = levelB_q;
  assign policyReg = policy_q;
endmodule // lps_protection_status_regs

// ===== verification/lps_psr_assertions.sv
`timescale 1ns/1ps
module lps_psr_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic [7:0] policyReg,
  // Level strobes and levels
  input wire logic levelWriteA,
  input wire logic levelWriteB,
  input wire logic [3:0] levelWdataA,
  input wire logic [3:0] levelWdataB,
  input wire logic [3:0] outputLevelSelectA,
  input wire logic [3:0] outputLevelSelectB,
  // Comparators and enables
  input wire logic overloadRawA,
  input wire logic overloadRawB,
  input wire logic overtempRaw,
  input wire logic lowSupplyRaw,
  input wire logic outputEnableA,
  input wire logic outputEnableB
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rd0 = regRead && regAddr == 8'h00;
  // --------
  // Status
  // --------
  AST_OVLD_A: assert property ((overloadRawA [*6] ##0 rd0) |=> regRdata[0])
    else $error("overload A not reported");
  AST_OVLD_B: assert property (((!overloadRawB) [*6] ##0 rd0) |=> !regRdata[1])
    else $error("overload B reported while clear");
  AST_HOT: assert property ((overtempRaw [*6] ##0 rd0) |=> regRdata[6])
    else $error("overtemperature not reported");
  AST_SUP: assert property ((lowSupplyRaw [*6] ##0 rd0) |=> regRdata[7])
    else $error("low supply not reported");
  AST_RSV: assert property (rd0 |=> regRdata[5:2] == 4'h0)
    else $error("reserved status bits set");
  AST_SPARE: assert property (regRead && regAddr == 8'h01 |=> regRdata == 8'h00)
    else $error("spare status not zero");
  AST_RESET: assert property ($fell(rst) |-> regRdata == 8'h00 && policyReg == 8'h00)
    else $error("not cleared by reset");
  // --------
  // Output gating
  // --------
  AST_LATCH: assert property ((policyReg[6] && overtempRaw) [*5] |=>
    outputLevelSelectA == 4'h0 && !outputEnableA) else $error("level not cleared");
  AST_HOT_OFF: assert property (overtempRaw [*5] |=> !outputEnableA && !outputEnableB)
    else $error("output on during overtemperature");
  AST_KEEP: assert property ((!policyReg[6] && overtempRaw && !levelWriteA) [*5] |=>
    outputLevelSelectA == $past(outputLevelSelectA, 5)) else $error("stored level lost");
  AST_STANDBY: assert property (outputLevelSelectA == 4'h0 && !levelWriteA |=>
    !outputEnableA) else $error("output on without level");
  cover property (rd0);
  cover property (policyReg[6] && overtempRaw);
  cover property (outputEnableA && outputEnableB);
endmodule // lps_psr_assertions
bind lps_protection_status_regs lps_psr_assertions lps_psr_assertions_inst (.*);

// ===== verification/lps_host_model.sv
`timescale 1ns/1ps
module lps_host_model (
  // Bus master side
  input wire logic clk,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata
);
  initial {regWrite, regRead, regAddr, regWdata} = 18'h0;
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    {regAddr, regWdata, regWrite} = {a, d & 8'h5f, 1'b1};
    @(negedge clk);
    regWrite = 1'b0;
    regWdata = ~regWdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    {regAddr, regRead} = {a, 1'b1};
    @(negedge clk);
    d = regRdata;
    regRead = 1'b0;
  endtask
endmodule // lps_host_model

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk, rst, regWrite, regRead, levelWriteA, levelWriteB, outputEnableA, outputEnableB;
  logic overloadRawA, overloadRawB, overtempRaw, lowSupplyRaw;
  logic [7:0] regAddr, regWdata, regRdata, policyReg, rdv;
  logic [3:0] levelWdataA, levelWdataB, outputLevelSelectA, outputLevelSelectB;
  int errors = 0, n_compared = 0;
  lps_protection_status_regs lps_protection_status_regs_inst (.*);
  lps_host_model lps_host_model_inst (.*);
  task automatic chk(input string nm, input logic [7:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    lps_host_model_inst.wr(a, d);
  endtask
  task automatic rdc(input logic [7:0] a, exp);
    lps_host_model_inst.rd(a, rdv);
    chk($sformatf("reg %h", a), exp, rdv);
  endtask
  // Enables A and B over stored level A
  task automatic outs(input logic [7:0] exp);
    chk("outputs", exp, {outputEnableA, outputEnableB, 2'b00, outputLevelSelectA});
  endtask
  task automatic lvl(input logic [3:0] a, b);
    @(negedge clk);
    {levelWriteA, levelWriteB, levelWdataA, levelWdataB} = {2'b11, a, b};
    @(negedge clk);
    {levelWriteA, levelWriteB} = 2'b00;
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #1000000;
    errors++;
    end_sim;
  end
  // ------------
  // Tests
  // ------------
  initial begin
    rst = 1'b1;
    {levelWriteA, levelWriteB, levelWdataA, levelWdataB} = 10'h0;
    {overloadRawA, overloadRawB, overtempRaw, lowSupplyRaw} = 4'h0;
    cyc(12);
    rst = 1'b0;
    rdc(8'h00, 8'h00);
    rdc(8'h01, 8'h00);
    rdc(8'h07, 8'h00);
    $display("test reset done");
    {overloadRawA, lowSupplyRaw} = 2'b11;
    cyc(5);
    rdc(8'h00, 8'h81);
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h5f);
    rdc(8'h00, 8'h81);
    rdc(8'h01, 8'h00);
    {overloadRawA, overloadRawB, lowSupplyRaw} = 3'b010;
    cyc(5);
    rdc(8'h00, 8'h02);
    overloadRawB = 1'b0;
    $display("test status done");
    lvl(4'h5, 4'ha);
    cyc(5);
    outs(8'hc5);
    chk("level B", 8'h0a, {4'h0, outputLevelSelectB});
    overtempRaw = 1'b1;
    cyc(5);
    rdc(8'h00, 8'h40);
    outs(8'h05);
    chk("level B", 8'h0a, {4'h0, outputLevelSelectB});
    overtempRaw = 1'b0;
    cyc(5);
    outs(8'hc5);
    $display("test auto restart done");
    wr(8'h05, 8'h40);
    chk("policy", 8'h40, policyReg);
    rdc(8'h05, 8'h40);
    overtempRaw = 1'b1;
    cyc(5);
    outs(8'h00);
    chk("level B", 8'h00, {4'h0, outputLevelSelectB});
    overtempRaw = 1'b0;
    cyc(5);
    outs(8'h00);
    lvl(4'h3, 4'h3);
    cyc(2);
    outs(8'hc3);
    chk("level B", 8'h03, {4'h0, outputLevelSelectB});
    $display("test latched done");
    wr(8'h05, 8'h00);
    overloadRawA = 1'b1;
    cyc(5);
    outs(8'h43);
    overloadRawA = 1'b0;
    cyc(5);
    outs(8'hc3);
    $display("test overload done");
    wr(8'h05, 8'h08);
    chk("policy", 8'h08, policyReg);
    overloadRawA = 1'b1;
    cyc(5);
    // Restart policy 1 masks overload from the gate, so the gate stays open
    outs(8'hc3);
    rdc(8'h00, 8'h01);
    overtempRaw = 1'b1;
    cyc(5);
    outs(8'h03);
    $display("test overload policy done");
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    rdc(8'h00, 8'h00);
    outs(8'h00);
    chk("policy", 8'h00, policyReg);
    cyc(5);
    rdc(8'h00, 8'h41);
    {overloadRawA, overtempRaw} = 2'b00;
    $display("test mid-run reset done");
    end_sim;
  end
endmodule // testbench
